// ==== hdl/epic_ctrl.sv ====
// Eight-source priority interrupt controller with AXI4-Lite registers
//
// Functional notes
// - Writing control bit 4 as zero returns the controller to reset; status and enable registers keep their values.
// - Control bit 3 zero locks delivery after one interrupt is delivered.
// - Control bit 2 zero stops delivering any request to the processor.
// - Writing control bit 1 as zero re-allows the next pending interrupt.
// - Writing control bit 0 as zero discards all pending requests.
// - Control bits 7 to 5 are ignored; control reads are undefined.
// - Any write to the return register acknowledges the served request.
// - Each source has a 3-bit priority; zero disables that source.
// - Priority one ranks lowest, seven highest, when choosing a request.
// - Priority register: odd source in bits 6-4, even in 2-0.
// - First two priority registers serve sources 0-1 and 2-3.
// - Source 2 is the 1 ms timer tick, source 3 bus-1 master.
// - Third priority register: source 5 upper, source 4 lower.
// - Fourth priority register: source 7 external pin, source 6 lower.
// - Priorities reset to zero; priority reads are undefined.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module epic_ctrl (
    input  wire logic                           CLK_I,
    input  wire logic                           RESET_N_I,
    input  wire logic [2:0]                     TIMER_REQ_I,
    input  wire logic                           BUS1_MST_REQ_I,
    input  wire logic                           BUS1_SLV_REQ_I,
    input  wire logic                           BUS2_MST_REQ_I,
    input  wire logic                           BUS2_SLV_REQ_I,
    input  wire logic                           EXTERNAL_REQUEST_PIN_I,
    output logic                                CPU_IRQ_O,
    output logic [epic_pkg::SRC_W-1:0]          CUR_SRC_O,
    output logic                                IRQ_O,
    input  wire logic [epic_pkg::ADDR_W-1:0]    AWADDR,
    input  wire logic                           AWVALID,
    output logic                                AWREADY,
    input  wire logic [31:0]                    WDATA,
    input  wire logic [3:0]                     WSTRB,
    input  wire logic                           WVALID,
    output logic                                WREADY,
    output logic [1:0]                          BRESP,
    output logic                                BVALID,
    input  wire logic                           BREADY,
    input  wire logic [epic_pkg::ADDR_W-1:0]    ARADDR,
    input  wire logic                           ARVALID,
    output logic                                ARREADY,
    output logic [31:0]                         RDATA,
    output logic [1:0]                          RRESP,
    output logic                                RVALID,
    input  wire logic                           RREADY
);
    localparam int N = epic_pkg::NSRC;
    // Bus slave state
    logic                          aw_hold_q, aw_hold_d;
    logic [epic_pkg::ADDR_W-1:0]   awaddr_q, awaddr_d;
    logic                          w_hold_q, w_hold_d;
    logic [7:0]                    wdata_q, wdata_d;
    logic                          wstb_q, wstb_d;
    logic                          awready_q, awready_d;
    logic                          wready_q, wready_d;
    logic                          bvalid_q, bvalid_d;
    logic [1:0]                    bresp_q, bresp_d;
    logic                          arready_q, arready_d;
    logic                          rvalid_q, rvalid_d;
    logic [31:0]                   rdata_q, rdata_d;
    logic [1:0]                    rresp_q, rresp_d;
    epic_pkg::epic_wr_t            wr;
    // Controller state
    epic_pkg::epic_ctl_t           ctl_q, ctl_d;
    logic [N-1:0][epic_pkg::PRI_W-1:0] pri_q, pri_d;
    logic [N-1:0]                  pend_q, pend_d;
    epic_pkg::epic_svc_t           svc_q, svc_d;
    logic [epic_pkg::SRC_W-1:0]    cur_q, cur_d;
    logic                          lock_q, lock_d;
    logic                          cpu_irq_q, cpu_irq_d;
    logic [epic_pkg::EV_W-1:0]     stat_q, stat_d;
    logic [epic_pkg::EV_W-1:0]     en_q, en_d;
    logic                          irq_q, irq_d;
    logic [N-1:0]                  src;
    logic [N-1:0]                  pri_hit;
    logic [N-1:0][epic_pkg::PRI_W-1:0] pri_new;
    logic                          cand_v;
    logic [epic_pkg::SRC_W-1:0]    cand_idx;
    logic [epic_pkg::PRI_W-1:0]    cand_pri;
    logic                          deliver;
    logic                          ctl_wr, ret_wr, soft_rst, clr_all, allow;
    logic [epic_pkg::EV_W-1:0]     ev;
    // Gather the requesters into source order
    assign src[epic_pkg::SRC_TIMER1]  = TIMER_REQ_I[0];
    assign src[epic_pkg::SRC_TIMER2]  = TIMER_REQ_I[1];
    assign src[epic_pkg::SRC_TIMER3]  = TIMER_REQ_I[2];
    assign src[epic_pkg::SRC_B1_MST]  = BUS1_MST_REQ_I;
    assign src[epic_pkg::SRC_B1_SLV]  = BUS1_SLV_REQ_I;
    assign src[epic_pkg::SRC_B2_MST]  = BUS2_MST_REQ_I;
    assign src[epic_pkg::SRC_B2_SLV]  = BUS2_SLV_REQ_I;
    assign src[epic_pkg::SRC_EXT_PIN] = EXTERNAL_REQUEST_PIN_I;
    function automatic logic mapped(input logic [epic_pkg::IDX_W-1:0] i);
        mapped = (i >= epic_pkg::IDX_CTL && i <= epic_pkg::IDX_PRI76) ||
                 (i >= epic_pkg::IDX_STAT && i <= epic_pkg::IDX_STATE);
    endfunction
    // AXI4-Lite slave; address and data may arrive in either order
    always_comb begin
        logic aw_take, w_take, have_aw, have_w, do_wr;
        logic [epic_pkg::ADDR_W-1:0] a;
        logic [epic_pkg::IDX_W-1:0]  ri;
        aw_take   = AWVALID && awready_q;
        w_take    = WVALID && wready_q;
        have_aw   = aw_hold_q || aw_take;
        have_w    = w_hold_q || w_take;
        do_wr     = have_aw && have_w && !bvalid_q;
        a         = aw_take ? AWADDR : awaddr_q;
        ri        = ARADDR[epic_pkg::IDX_LSB +: epic_pkg::IDX_W];
        aw_hold_d = aw_hold_q;
        awaddr_d  = awaddr_q;
        w_hold_d  = w_hold_q;
        wdata_d   = wdata_q;
        wstb_d    = wstb_q;
        bvalid_d  = bvalid_q && !BREADY;
        bresp_d   = bresp_q;
        if (aw_take) begin
            aw_hold_d = 1'b1;
            awaddr_d  = AWADDR;
        end
        if (w_take) begin
            w_hold_d = 1'b1;
            wdata_d  = WDATA[7:0];
            wstb_d   = WSTRB[0];
        end
        wr.en   = 1'b0;
        wr.idx  = a[epic_pkg::IDX_LSB +: epic_pkg::IDX_W];
        wr.data = w_take ? WDATA[7:0] : wdata_q;
        if (do_wr) begin
            // Only byte lane 0 carries register data
            wr.en     = mapped(wr.idx) && (w_take ? WSTRB[0] : wstb_q);
            bvalid_d  = 1'b1;
            bresp_d   = mapped(wr.idx) ? epic_pkg::RESP_OKAY
                                       : epic_pkg::RESP_SLVERR;
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d  = !w_hold_d && !bvalid_d;
        // Read: control, return and priority words read as zero
        rvalid_d  = rvalid_q && !RREADY;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (ARVALID && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(ri) ? epic_pkg::RESP_OKAY
                                  : epic_pkg::RESP_SLVERR;
            case (ri)
                epic_pkg::IDX_STAT:  rdata_d = 32'(stat_q);
                epic_pkg::IDX_EN:    rdata_d = 32'(en_q);
                epic_pkg::IDX_STATE: rdata_d = {16'h0, pend_q, 3'h0,
                                                lock_q, svc_q, cur_q};
                default:             rdata_d = 32'h0;
            endcase
        end
        arready_d = !rvalid_d;
    end
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= '0;
            w_hold_q  <= 1'b0;
            wdata_q   <= 8'h0;
            wstb_q    <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= epic_pkg::RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= epic_pkg::RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            awaddr_q  <= awaddr_d;
            w_hold_q  <= w_hold_d;
            wdata_q   <= wdata_d;
            wstb_q    <= wstb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end
    // Per-source priority field decode; bits 7 and 3 fall away here
    for (genvar g = 0; g < N; g++) begin : g_src
        assign pri_hit[g] = wr.en && (wr.idx == epic_pkg::IDX_PRI10 +
                            epic_pkg::IDX_W'(g / 2));
        assign pri_new[g] = (g % 2 == 1)
            ? wr.data[epic_pkg::PRI_HI_LSB +: epic_pkg::PRI_W]
            : wr.data[epic_pkg::PRI_LO_LSB +: epic_pkg::PRI_W];
    end
    // Best pending source; scanning up with >= hands ties to higher ones
    always_comb begin
        cand_v   = 1'b0;
        cand_idx = '0;
        cand_pri = epic_pkg::PRI_OFF;
        for (int i = 0; i < N; i++) begin
            if (pend_q[i] && pri_q[i] != epic_pkg::PRI_OFF &&
                pri_q[i] >= cand_pri) begin
                cand_v   = 1'b1;
                cand_idx = epic_pkg::SRC_W'(i);
                cand_pri = pri_q[i];
            end
        end
    end
    assign ctl_wr   = wr.en && wr.idx == epic_pkg::IDX_CTL;
    assign ret_wr   = wr.en && wr.idx == epic_pkg::IDX_RET;
    assign soft_rst = ctl_wr && !wr.data[epic_pkg::CTL_RESET_BIT];
    assign clr_all  = ctl_wr && !wr.data[epic_pkg::CTL_CLEAR_BIT];
    assign allow    = ctl_wr && !wr.data[epic_pkg::CTL_ALLOW_BIT];
    assign deliver  = svc_q == epic_pkg::EPIC_IDLE && cand_v &&
                      ctl_q.enable && !lock_q;
    // Controller next state
    always_comb begin
        ctl_d  = ctl_q;
        pri_d  = pri_q;
        pend_d = pend_q;
        svc_d  = svc_q;
        cur_d  = cur_q;
        lock_d = lock_q;
        ev     = '0;
        if (allow)
            lock_d = 1'b0;
        if (clr_all)
            pend_d = '0;
        if (ctl_wr) begin
            ctl_d.one_shot_n = wr.data[epic_pkg::CTL_ONESHOT_BIT];
            ctl_d.enable     = wr.data[epic_pkg::CTL_ENABLE_BIT];
        end
        for (int i = 0; i < N; i++) begin
            if (pri_hit[i])
                pri_d[i] = pri_new[i];
        end
        if (ret_wr) begin
            if (svc_q == epic_pkg::EPIC_SERVING) begin
                svc_d = epic_pkg::EPIC_IDLE;
                ev[epic_pkg::EV_RETURN] = 1'b1;
            end else begin
                ev[epic_pkg::EV_STRAY] = 1'b1;
            end
        end
        if (deliver) begin
            svc_d          = epic_pkg::EPIC_SERVING;
            cur_d          = cand_idx;
            pend_d[cand_idx] = 1'b0;
            ev[epic_pkg::EV_DELIVER] = 1'b1;
            if (!ctl_q.one_shot_n)
                lock_d = 1'b1;
        end
        // New requests win over any clear in the same cycle
        pend_d = pend_d | src;
        if (soft_rst) begin
            ctl_d  = epic_pkg::CTL_RESET;
            pri_d  = '0;
            pend_d = src;
            svc_d  = epic_pkg::EPIC_IDLE;
            cur_d  = '0;
            lock_d = 1'b0;
        end
        cpu_irq_d = svc_d == epic_pkg::EPIC_SERVING && ctl_d.enable;
        stat_d = stat_q;
        en_d   = en_q;
        if (wr.en && wr.idx == epic_pkg::IDX_CLR)
            stat_d = stat_d & ~wr.data[epic_pkg::EV_W-1:0];
        if (wr.en && wr.idx == epic_pkg::IDX_EN)
            en_d = wr.data[epic_pkg::EV_W-1:0];
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & en_d);
    end
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ctl_q     <= epic_pkg::CTL_RESET;
            pri_q     <= '0;
            pend_q    <= '0;
            svc_q     <= epic_pkg::EPIC_IDLE;
            cur_q     <= '0;
            lock_q    <= 1'b0;
            cpu_irq_q <= 1'b0;
            stat_q    <= '0;
            en_q      <= '0;
            irq_q     <= 1'b0;
        end else begin
            ctl_q     <= ctl_d;
            pri_q     <= pri_d;
            pend_q    <= pend_d;
            svc_q     <= svc_d;
            cur_q     <= cur_d;
            lock_q    <= lock_d;
            cpu_irq_q <= cpu_irq_d;
            stat_q    <= stat_d;
            en_q      <= en_d;
            irq_q     <= irq_d;
        end
    end
    assign CPU_IRQ_O = cpu_irq_q;
    assign CUR_SRC_O = cur_q;
    assign IRQ_O     = irq_q;
    assign AWREADY   = awready_q;
    assign WREADY    = wready_q;
    assign BVALID    = bvalid_q;
    assign BRESP     = bresp_q;
    assign ARREADY   = arready_q;
    assign RVALID    = rvalid_q;
    assign RDATA     = rdata_q;
    assign RRESP     = rresp_q;
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic better_waiting;
    always_comb begin
        better_waiting = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (pend_q[i] && pri_q[i] != epic_pkg::PRI_OFF &&
                (pri_q[i] > cand_pri ||
                 (pri_q[i] == cand_pri && i > int'(cand_idx))))
                better_waiting = 1'b1;
        end
    end
    sequence seq_deliver;
        deliver && !soft_rst;
    endsequence
    sequence seq_return;
        ret_wr && svc_q == epic_pkg::EPIC_SERVING && !soft_rst;
    endsequence
    AST_SOFT_RESET: assert property (soft_rst |=> pri_q == '0 &&
        svc_q == epic_pkg::EPIC_IDLE && !lock_q && !CPU_IRQ_O)
        else $error("soft reset left state behind");
    AST_ONE_SHOT: assert property (seq_deliver ##0 !ctl_q.one_shot_n
        |=> lock_q ##0 svc_q == epic_pkg::EPIC_SERVING)
        else $error("one-shot lock not set");
    AST_DISABLED: assert property (!ctl_q.enable && !ctl_wr
        |=> !deliver && !CPU_IRQ_O)
        else $error("delivery while disabled");
    AST_ALLOW: assert property (allow && !deliver && !soft_rst
        |=> !lock_q)
        else $error("allow-next did not unlock");
    AST_CLEAR: assert property (clr_all && !soft_rst
        |=> (pend_q & ~$past(src)) == '0)
        else $error("clear-all left requests");
    AST_RETURN: assert property (seq_return |=>
        svc_q == epic_pkg::EPIC_IDLE && !CPU_IRQ_O)
        else $error("return write not taken");
    AST_PRI_NONZERO: assert property (deliver |->
        pri_q[cand_idx] != epic_pkg::PRI_OFF)
        else $error("disabled source delivered");
    AST_BEST: assert property (deliver |-> !better_waiting)
        else $error("delivered a lower ranked source");
    AST_FIELD: assert property (wr.en && wr.idx == epic_pkg::IDX_PRI10
        && !soft_rst |=> pri_q[epic_pkg::SRC_TIMER2] ==
        $past(wr.data[epic_pkg::PRI_HI_LSB +: epic_pkg::PRI_W]))
        else $error("priority field misplaced");
    AST_LATCH: assert property (pend_q[epic_pkg::SRC_EXT_PIN] &&
        !clr_all && !soft_rst && !(deliver &&
        cand_idx == epic_pkg::SRC_W'(epic_pkg::SRC_EXT_PIN))
        |=> pend_q[epic_pkg::SRC_EXT_PIN])
        else $error("pending request lost");
    AST_IRQ_HOLD: assert property (seq_deliver ##0 !ctl_wr ##1
        (!ret_wr && !ctl_wr)[*2] |-> CPU_IRQ_O ##1 CPU_IRQ_O)
        else $error("processor request dropped early");
endmodule

// ==== shared/epic_pkg.sv ====
// Shared constants and types for the eight-source priority interrupt block
package epic_pkg;
    // Bus geometry: registers sit at word index, byte address is index * 4
    localparam int ADDR_W  = 12;
    localparam int IDX_W   = 10;
    localparam int IDX_LSB = 2;
    localparam int NSRC    = 8;
    localparam int SRC_W   = 3;
    localparam int PRI_W   = 3;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_CTL   = 10'h21c;
    localparam logic [IDX_W-1:0] IDX_RET   = 10'h21d;
    localparam logic [IDX_W-1:0] IDX_PRI10 = 10'h21e;
    localparam logic [IDX_W-1:0] IDX_PRI32 = 10'h21f;
    localparam logic [IDX_W-1:0] IDX_PRI54 = 10'h220;
    localparam logic [IDX_W-1:0] IDX_PRI76 = 10'h221;
    localparam logic [IDX_W-1:0] IDX_STAT  = 10'h240;
    localparam logic [IDX_W-1:0] IDX_CLR   = 10'h241;
    localparam logic [IDX_W-1:0] IDX_EN    = 10'h242;
    localparam logic [IDX_W-1:0] IDX_STATE = 10'h243;

    // Control register bit positions
    localparam int CTL_RESET_BIT   = 4;
    localparam int CTL_ONESHOT_BIT = 3;
    localparam int CTL_ENABLE_BIT  = 2;
    localparam int CTL_ALLOW_BIT   = 1;
    localparam int CTL_CLEAR_BIT   = 0;

    // Priority field positions inside a priority register
    localparam int PRI_HI_LSB = 4;
    localparam int PRI_LO_LSB = 0;
    localparam logic [PRI_W-1:0] PRI_OFF = 3'h0;

    // Source numbering; timer three is the 1 ms tick
    localparam int SRC_TIMER1   = 0;
    localparam int SRC_TIMER2   = 1;
    localparam int SRC_TIMER3   = 2;
    localparam int SRC_B1_MST   = 3;
    localparam int SRC_B1_SLV   = 4;
    localparam int SRC_B2_MST   = 5;
    localparam int SRC_B2_SLV   = 6;
    localparam int SRC_EXT_PIN  = 7;

    // Sticky event bits of the status register
    localparam int EV_W       = 3;
    localparam int EV_DELIVER = 0;
    localparam int EV_RETURN  = 1;
    localparam int EV_STRAY   = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        EPIC_IDLE    = 1'b0,
        EPIC_SERVING = 1'b1
    } epic_svc_t;

    // Stored level bits of the control register
    typedef struct packed {
        logic one_shot_n;
        logic enable;
    } epic_ctl_t;

    localparam epic_ctl_t CTL_RESET = '{one_shot_n: 1'b1, enable: 1'b1};

    // One register write as seen by the core
    typedef struct packed {
        logic             en;
        logic [IDX_W-1:0] idx;
        logic [7:0]       data;
    } epic_wr_t;
endpackage

// ==== verif/epic_src_model.sv ====
// Model of the request sources on the far side of the controller
`timescale 1ns/1ps
module epic_src_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] fire_i,
    output logic [2:0]      timer_req_o,
    output logic [3:0]      bus_req_o,
    output logic            pin_req_o
);
    // One-cycle pulses; idle lines stay low so no stale level re-requests
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_req_o <= 3'h0;
            bus_req_o   <= 4'h0;
            pin_req_o   <= 1'b0;
        end else begin
            timer_req_o <= fire_i[2:0];
            bus_req_o   <= fire_i[6:3];
            pin_req_o   <= fire_i[7];
        end
    end
endmodule

// ==== verif/epic_ctrl_bench.sv ====
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module epic_ctrl_bench;
    localparam logic [11:0] CTL = 12'h870, RET = 12'h874, P10 = 12'h878,
        P32 = 12'h87c, P54 = 12'h880, P76 = 12'h884, STA = 12'h900,
        CLR = 12'h904, ENA = 12'h908, STE = 12'h90c, BAD = 12'h800;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        irq, cpu_irq, awready, wready, bvalid, arready, rvalid;
    logic        preq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [2:0]  cur, treq;
    logic [3:0]  breq;
    logic [7:0]  fire;
    int          mismatches, total_checks, cycles;

    epic_src_model src (
        .clk_i(clk), .rst_n_i(rst_n), .fire_i(fire),
        .timer_req_o(treq), .bus_req_o(breq), .pin_req_o(preq)
    );
    epic_ctrl uut (
        .CLK_I(clk), .RESET_N_I(rst_n), .TIMER_REQ_I(treq),
        .BUS1_MST_REQ_I(breq[0]), .BUS1_SLV_REQ_I(breq[1]),
        .BUS2_MST_REQ_I(breq[2]), .BUS2_SLV_REQ_I(breq[3]),
        .EXTERNAL_REQUEST_PIN_I(preq), .CPU_IRQ_O(cpu_irq),
        .CUR_SRC_O(cur), .IRQ_O(irq), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard; the whole sequence needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        fire <= m;
        @(posedge clk);
        fire <= 8'h0;
    endtask

    // Bounded wait for the processor request, then compare its level
    task automatic wirq(input logic e);
        for (int i = 0; i < 12 && cpu_irq !== 1'b1; i++) @(posedge clk);
        chk({31'h0, cpu_irq}, {31'h0, e});
    endtask

    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, fire} = '0;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdr(STE);
        chk(rd, 32'h0);
        pulse(8'hff);
        wirq(1'b0);
        rdr(CTL);
        chk(rd, 32'h0);
        // Program priorities while disabled so ranking is seen all at once
        wr(CTL, 8'h1a);
        chk({30'h0, rs}, {30'h0, epic_pkg::RESP_OKAY});
        wr(P10, 8'h21);
        wr(P32, 8'h43);
        wr(P54, 8'h65);
        wr(P76, 8'h77);
        pulse(8'hff);
        wr(CTL, 8'h1f);
        for (int k = 0; k < 8; k++) begin
            wirq(1'b1);
            chk({29'h0, cur}, 32'(7 - k));
            wr(RET, 8'(k * 37));
            chk({31'h0, cpu_irq}, 32'h0);
        end
        // Sticky status, enable and clear drive the system interrupt
        rdr(STA);
        chk(rd, 32'h3);
        wr(ENA, 8'h01);
        rdr(ENA);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(CLR, 8'h07);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(RET, 8'h00);
        rdr(STA);
        chk(rd, 32'h4);
        // Zero priority, global disable, then clear-all
        wr(P76, 8'h07);
        pulse(8'h80);
        wirq(1'b0);
        wr(CTL, 8'h1b);
        pulse(8'h40);
        wirq(1'b0);
        rdr(STE);
        chk(rd & 32'h4000, 32'h4000);
        wr(CTL, 8'h1f);
        wirq(1'b1);
        chk({29'h0, cur}, 32'h6);
        wr(RET, 8'h00);
        wr(CTL, 8'h1b);
        pulse(8'h40);
        wr(CTL, 8'h1a);
        wr(CTL, 8'h1f);
        wirq(1'b0);
        // Lock after one delivery, released by the allow-next write
        wr(CTL, 8'h17);
        pulse(8'h50);
        wirq(1'b1);
        chk({29'h0, cur}, 32'h6);
        wr(RET, 8'h5a);
        wirq(1'b0);
        wr(CTL, 8'hf5);
        wirq(1'b1);
        chk({29'h0, cur}, 32'h4);
        wr(RET, 8'h00);
        // Soft reset drops pending, lock and all priorities
        wr(CTL, 8'h1b);
        pulse(8'h20);
        wr(CTL, 8'h0f);
        rdr(STE);
        chk(rd & 32'hff18, 32'h0);
        pulse(8'h20);
        wirq(1'b0);
        // Unmapped place is refused
        wr(BAD, 8'hff);
        chk({30'h0, rs}, {30'h0, epic_pkg::RESP_SLVERR});
        rdr(BAD);
        chk(rd, 32'h0);
        chk({30'h0, rs}, {30'h0, epic_pkg::RESP_SLVERR});
        end_sim();
    end
endmodule
